// ### converter_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// converter and test-vector source
// ----------------------------------------------------------------
module converter_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic adcReady,
    input wire logic go,
    input wire logic slow,
    output logic adcValid,
    output logic [11:0] adcData,
    output logic signed [11:0] vecCos,
    output logic signed [11:0] vecSin
);
    logic [35:0] mem [0:1023];
    int idx;
    logic tk;
    logic g0;
    initial begin
        adcValid = 1'b0;
        adcData = 12'h000;
        vecCos = 12'sh000;
        vecSin = 12'sh000;
        idx = 1024;
    end
    // one word per handshake, held until taken
    always @(posedge clk) begin
        tk = adcValid && adcReady && ce;
        g0 = go;
        #2;
        if (!rst_n) idx = 1024;
        else if (g0) idx = 0;
        else if (tk) idx = idx + 1;
        if (adcValid && !tk && idx < 1024) begin
        end else if (idx < 1024 && (!slow || $urandom_range(0, 1) == 1)) begin
            adcValid = 1'b1;
            {adcData, vecCos, vecSin} = mem[idx];
        end else begin
            adcValid = 1'b0;
            adcData = ~adcData;
            vecCos = ~vecCos;
            vecSin = ~vecSin;
        end
    end
endmodule : converter_model

// ### dft_engine_pkg.sv
package dft_engine_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REAL_HI_ADDR = 8'h94;
    localparam logic [7:0] REAL_LO_ADDR = 8'h95;
    localparam logic [7:0] IMAG_HI_ADDR = 8'h96;
    localparam logic [7:0] IMAG_LO_ADDR = 8'h97;
    localparam logic [7:0] STATUS_ADDR = 8'h8F;
    localparam int DONE_BIT = 2;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int ADC_W = 12;
    localparam int VEC_W = 12;
    localparam int RES_W = 16;
    localparam int ACC_W = 37;
    localparam int RES_LSB = 21;
    localparam int BUF_W = ADC_W + 2 * VEC_W;
    localparam int BUF_DEPTH = 2;
    localparam logic [9:0] LAST_INDEX = 10'h3FF;
    localparam logic signed [13:0] ADC_MIDSCALE = 14'sh0800;
    localparam logic signed [15:0] HIGH_GAIN = 16'sh0005;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int SAMPLE_RATE_SPS = 250_000;
    localparam int SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_SPS;
    localparam logic [6:0] PACE_LAST = 7'(SAMPLE_PERIOD_CYC - 1);

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEAS = 2'b01,
        ST_DONE = 2'b10
    } eng_state_e;

    typedef struct packed {
        eng_state_e st;
        logic [9:0] cnt;
        logic signed [ACC_W-1:0] accRe;
        logic signed [ACC_W-1:0] accIm;
        logic [RES_W-1:0] realRes;
        logic [RES_W-1:0] imagRes;
        logic point_done_flag;
        logic [6:0] paceCnt;
        logic convStart;
        logic [7:0] rdData;
    } eng_s;

    typedef struct packed {
        logic [BUF_DEPTH-1:0][BUF_W-1:0] mem;
        logic wrPtr;
        logic rdPtr;
        logic [1:0] count;
        logic inRdy;
        logic outVld;
    } buf_s;

endpackage : dft_engine_pkg

// ### dft_impedance_result_engine.sv
`timescale 1ns/10ps
module dft_impedance_result_engine (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic startPoint,
    input wire logic receive_gain_select_bit,
    input wire logic adcValid,
    output logic adcReady,
    input wire logic [dft_engine_pkg::ADC_W-1:0] adcData,
    input wire logic signed [dft_engine_pkg::VEC_W-1:0] vecCos,
    input wire logic signed [dft_engine_pkg::VEC_W-1:0] vecSin,
    output logic convStart,
    input wire logic [7:0] regAddr,
    output logic [7:0] regRdData,
    output logic pointDone
);

    dft_engine_pkg::eng_s r_reg;
    dft_engine_pkg::eng_s r_next;
    logic bufValid;
    logic bufReady;
    logic [dft_engine_pkg::BUF_W-1:0] bufData;
    logic pop;
    logic complete;
    logic signed [13:0] centered;
    logic signed [15:0] gained;
    logic signed [27:0] prodRe;
    logic signed [27:0] prodIm;
    logic signed [dft_engine_pkg::ACC_W-1:0] accReNext;
    logic signed [dft_engine_pkg::ACC_W-1:0] accImNext;

    // ------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] read_byte(
        input logic [7:0] addr,
        input logic [15:0] re,
        input logic [15:0] im,
        input logic done
    );
        logic [7:0] d;
        d = dft_engine_pkg::UNMAPPED_DATA;
        case (addr)
            dft_engine_pkg::REAL_HI_ADDR: d = re[15:8];
            dft_engine_pkg::REAL_LO_ADDR: d = re[7:0];
            dft_engine_pkg::IMAG_HI_ADDR: d = im[15:8];
            dft_engine_pkg::IMAG_LO_ADDR: d = im[7:0];
            dft_engine_pkg::STATUS_ADDR: d[dft_engine_pkg::DONE_BIT] = done;
            default: d = dft_engine_pkg::UNMAPPED_DATA;
        endcase
        return d;
    endfunction : read_byte

    // ------------------------------------------------------------
    // sample buffer
    // ------------------------------------------------------------
    sample_buffer u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .inValid(adcValid),
        .inReady(adcReady),
        .inData({adcData, vecCos, vecSin}),
        .outValid(bufValid),
        .outReady(bufReady),
        .outData(bufData)
    );

    assign bufReady = (r_reg.st == dft_engine_pkg::ST_MEAS);

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    always_comb begin
        centered = $signed({2'b00, bufData[35:24]})
            - dft_engine_pkg::ADC_MIDSCALE;
        if (receive_gain_select_bit) begin
            gained = 16'(centered) * dft_engine_pkg::HIGH_GAIN;
        end else begin
            gained = 16'(centered);
        end
        prodRe = 28'(gained) * 28'($signed(bufData[23:12]));
        prodIm = 28'(gained) * 28'($signed(bufData[11:0]));
        accReNext = r_reg.accRe + 37'(prodRe);
        accImNext = r_reg.accIm - 37'(prodIm);
    end

    assign pop = bufValid && bufReady;
    assign complete = pop && (r_reg.cnt == dft_engine_pkg::LAST_INDEX);

    // ------------------------------------------------------------
    // control
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.convStart = 1'b0;
        case (r_reg.st)
            dft_engine_pkg::ST_IDLE: begin
                r_next.st = dft_engine_pkg::ST_IDLE;
            end
            dft_engine_pkg::ST_MEAS: begin
                if (r_reg.paceCnt == dft_engine_pkg::PACE_LAST) begin
                    r_next.paceCnt = 7'd0;
                    r_next.convStart = 1'b1;
                end else begin
                    r_next.paceCnt = r_reg.paceCnt + 7'd1;
                end
                if (pop) begin
                    r_next.accRe = accReNext;
                    r_next.accIm = accImNext;
                    r_next.cnt = r_reg.cnt + 10'd1;
                end
                if (complete) begin
                    r_next.realRes = accReNext[36:21];
                    r_next.imagRes = accImNext[36:21];
                    r_next.point_done_flag = 1'b1;
                    r_next.st = dft_engine_pkg::ST_DONE;
                end
            end
            dft_engine_pkg::ST_DONE: begin
                r_next.st = dft_engine_pkg::ST_DONE;
            end
            default: begin
                r_next.st = dft_engine_pkg::ST_IDLE;
            end
        endcase
        if (startPoint) begin
            r_next.st = dft_engine_pkg::ST_MEAS;
            r_next.cnt = 10'd0;
            r_next.accRe = '0;
            r_next.accIm = '0;
            r_next.paceCnt = 7'd0;
            if (!complete) begin
                r_next.point_done_flag = 1'b0;
            end
        end
        r_next.rdData = read_byte(regAddr, r_reg.realRes,
            r_reg.imagRes, r_reg.point_done_flag);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.realRes <= dft_engine_pkg::RESULT_RESET;
            r_reg.imagRes <= dft_engine_pkg::RESULT_RESET;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign convStart = r_reg.convStart;
    assign regRdData = r_reg.rdData;
    assign pointDone = r_reg.point_done_flag;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    pace_bound_a: assert property (
        r_reg.paceCnt <= dft_engine_pkg::PACE_LAST)
        else $error("sample pacing counter overran");
    strobe_single_a: assert property (
        convStart |=> !convStart)
        else $error("converter strobe longer than one cycle");
    start_clears_a: assert property (
        startPoint |=> (r_reg.accRe == '0 && r_reg.accIm == '0
            && r_reg.cnt == 10'd0
            && r_reg.st == dft_engine_pkg::ST_MEAS))
        else $error("point start did not clear accumulators");
    done_sets_a: assert property (
        complete |=> pointDone)
        else $error("done flag not set on completion");
    index_step_a: assert property (
        (pop && !startPoint && !complete)
            |=> r_reg.cnt == $past(r_reg.cnt) + 10'd1)
        else $error("sample index did not advance");
    direct_drain_a: assert property (
        (bufValid && r_reg.st == dft_engine_pkg::ST_MEAS && !startPoint)
            |=> r_reg.cnt != $past(r_reg.cnt))
        else $error("engine stalled the converter words");
    result_hold_a: assert property (
        !complete |=> ($stable(r_reg.realRes) && $stable(r_reg.imagRes)))
        else $error("result changed without completion");
    result_slice_a: assert property (
        complete |=> r_reg.realRes == $past(accReNext[36:21]))
        else $error("real result is not the accumulator slice");
    gain_five_a: assert property (
        receive_gain_select_bit
            |-> gained == (16'(centered) <<< 2) + 16'(centered))
        else $error("high gain not applied");
    read_real_a: assert property (
        regAddr == dft_engine_pkg::REAL_HI_ADDR
            |=> regRdData == $past(r_reg.realRes[15:8]))
        else $error("real high byte read wrong");
    read_imag_a: assert property (
        regAddr == dft_engine_pkg::IMAG_LO_ADDR
            |=> regRdData == $past(r_reg.imagRes[7:0]))
        else $error("imaginary low byte read wrong");

    point_done_c: cover property ($rose(pointDone));
    input_stall_c: cover property (adcValid && !adcReady);
    high_gain_done_c: cover property (complete && receive_gain_select_bit);
    restart_c: cover property (pointDone && startPoint);

endmodule : dft_impedance_result_engine

// ### dft_impedance_result_engine_test.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// self-checking bench
// ----------------------------------------------------------------
module dft_impedance_result_engine_test;
    logic clk, rst_n, ce, startPoint, gainSel, go, slow, monIdle;
    logic adcValid, adcReady, convStart, pointDone;
    logic [11:0] adcData;
    logic signed [11:0] vecCos, vecSin;
    logic [7:0] regAddr, regRdData, v;
    logic [31:0] e;
    logic [31:0] expQ[$];
    int miscompares, n_checks, p, n;
    logic [15:0] re, im;
    real mag, magExp, gf, gfLast, gfMid, zEst;

    dft_impedance_result_engine DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
        .startPoint(startPoint), .receive_gain_select_bit(gainSel),
        .adcValid(adcValid), .adcReady(adcReady), .adcData(adcData),
        .vecCos(vecCos), .vecSin(vecSin), .convStart(convStart),
        .regAddr(regAddr), .regRdData(regRdData), .pointDone(pointDone));
    converter_model PM (.clk(clk), .rst_n(rst_n), .ce(ce),
        .adcReady(adcReady), .go(go), .slow(slow), .adcValid(adcValid),
        .adcData(adcData), .vecCos(vecCos), .vecSin(vecSin));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic waitHigh(ref logic s, input int lim);
        int k;
        for (k = 0; k < lim && s !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (s !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask : waitHigh

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #2 regAddr = a;
        @(posedge clk);
        #1 d = regRdData;
    endtask : rd

    // reference transform of the words held by the source
    function automatic logic [31:0] expected(input logic g);
        longint sr, si, x, c, s;
        sr = 0;
        si = 0;
        for (int i = 0; i < 1024; i++) begin
            x = longint'(PM.mem[i][35:24]) - 2048;
            x = g ? x * 5 : x;
            c = longint'($signed(PM.mem[i][23:12]));
            s = longint'($signed(PM.mem[i][11:0]));
            sr += x * c;
            si -= x * s;
        end
        return {sr[36:21], si[36:21]};
    endfunction : expected

    // ------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------
    initial begin
        monIdle = 1'b1;
        regAddr = 8'h00;
        forever begin
            @(posedge pointDone);
            monIdle = 1'b0;
            e = (expQ.size() > 0) ? expQ.pop_front() : 32'hFFFF_FFFF;
            rd(8'h94, v);
            chk(v, e[31:24]);
            re[15:8] = v;
            rd(8'h95, v);
            chk(v, e[23:16]);
            re[7:0] = v;
            rd(8'h96, v);
            chk(v, e[15:8]);
            im[15:8] = v;
            rd(8'h97, v);
            chk(v, e[7:0]);
            im[7:0] = v;
            rd(8'h8F, v);
            chk(v, 8'h04);
            rd(8'h90, v);
            chk(v, 8'h00);
            mag = $sqrt(real'($signed(re)) ** 2
                + real'($signed(im)) ** 2);
            magExp = $sqrt(real'($signed(e[31:16])) ** 2
                + real'($signed(e[15:0])) ** 2);
            chk(16'(int'(mag)), 16'(int'(magExp)));
            gf = (mag > 0.0) ? (1.0 / 1000.0) / mag : 0.0;
            gfMid = gfLast + (gf - gfLast) / 10.0e3 * 10.0e3;
            zEst = (gfMid * mag > 0.0) ? 1.0 / (gfMid * mag) : 0.0;
            chk(16'(int'(zEst)), 16'd1000);
            gfLast = gf;
            monIdle = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h0DE6));
        rst_n = 1'b0;
        ce = 1'b1;
        startPoint = 1'b0;
        gainSel = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        repeat (6) @(posedge clk);
        #2 rst_n = 1'b1;
        chk(adcReady, 1'b1);
        chk(pointDone, 1'b0);
        chk(regRdData, 8'h00);
        for (p = 0; p < 3; p++) begin
            for (int i = 0; i < 1024; i++)
                PM.mem[i] = (p == 0) ? {12'hFFF, 12'h7FF, 12'h800}
                                     : {4'($urandom), $urandom};
            gainSel = (p != 0);
            slow = (p == 1);
            expQ.push_back(expected(gainSel));
            if (p == 2) begin
                @(posedge clk);
                #2 go = 1'b1;
                @(posedge clk);
                #2 go = 1'b0;
                repeat (4) @(posedge clk);
                #1 chk(adcReady, 1'b0);
            end
            @(posedge clk);
            #2 startPoint = 1'b1;
            go = (p != 2);
            @(posedge clk);
            #2 startPoint = 1'b0;
            go = 1'b0;
            chk(pointDone, 1'b0);
            if (p == 0) begin
                for (n = 0; n < 200 && convStart !== 1'b1; n++) begin
                    @(posedge clk);
                    #1;
                end
                chk(16'(n), 16'd80);
                #1 ce = 1'b0;
                repeat (5) @(posedge clk);
                #2 ce = 1'b1;
            end
            waitHigh(pointDone, 6000);
            waitHigh(monIdle, 100);
        end
        summarize();
    end
endmodule : dft_impedance_result_engine_test

// ### sample_buffer.sv
`timescale 1ns/10ps
module sample_buffer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic inValid,
    output logic inReady,
    input wire logic [dft_engine_pkg::BUF_W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [dft_engine_pkg::BUF_W-1:0] outData
);

    dft_engine_pkg::buf_s b_reg;
    dft_engine_pkg::buf_s b_next;
    logic push;
    logic pop;
    logic [1:0] level;

    // ------------------------------------------------------------
    // two-entry ring
    // ------------------------------------------------------------
    always_comb begin
        b_next = b_reg;
        push = inValid && b_reg.inRdy;
        pop = b_reg.outVld && outReady;
        if (push) begin
            b_next.mem[b_reg.wrPtr] = inData;
            b_next.wrPtr = ~b_reg.wrPtr;
        end
        if (pop) begin
            b_next.rdPtr = ~b_reg.rdPtr;
        end
        level = b_reg.count + {1'b0, push} - {1'b0, pop};
        b_next.count = level;
        b_next.inRdy = (level != 2'(dft_engine_pkg::BUF_DEPTH));
        b_next.outVld = (level != 2'd0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            b_reg <= '0;
            b_reg.inRdy <= 1'b1;
        end else if (ce) begin
            b_reg <= b_next;
        end
    end

    assign inReady = b_reg.inRdy;
    assign outValid = b_reg.outVld;
    assign outData = b_reg.mem[b_reg.rdPtr];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    level_bound_a: assert property (b_reg.count <= 2'd2)
        else $error("buffer level above two");
    full_stall_a: assert property (
        (b_reg.count == 2'd2) |-> !b_reg.inRdy)
        else $error("buffer accepts while full");

endmodule : sample_buffer
